// file: design/sfp_defs.svh
// sfp_defs.svh: constants of the serial frame port, its word layout and its defaults
// assumes inclusion by bare name from the package and from the design file
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH
`define SFP_WORD_W      16
`define SFP_CNT_W       5
`define SFP_LAST_BIT    5'h0f
`define SFP_FULL_CNT    5'h10
`define SFP_MSB_IDX     4'hf
`define SFP_FIFO_DEPTH  16
`define SFP_PINS        8
`define SFP_BUSY_PIN    7
`define SFP_CH_W        3
`define SFP_CODE_W      12
`define SFP_DAC_BIT     15
`define SFP_OP_HI       14
`define SFP_OP_LO       11
`define SFP_PIN_HI      10
`define SFP_PIN_LO      8
`define SFP_CH_HI       14
`define SFP_CH_LO       12
`define SFP_OP_FN       4'h1
`define SFP_OP_BUSY     4'h2
`define SFP_OP_GPO      4'h3
`define SFP_OP_CONV     4'h4
`define SFP_OP_RB_CFG   4'h5
`define SFP_OP_RB_TEMP  4'h6
`define SFP_OP_RB_GPI   4'h7
`define SFP_TEMP_TAG    4'h8
`define SFP_CFG_RST     16'haaaa
`define SFP_TX_RST      16'h0000
`define SFP_GPO_RST     8'h00
`endif

// file: design/sfp_pkg.sv
// sfp_pkg: types shared by the serial frame port
// assumes the constants header sits beside it
`include "sfp_defs.svh"
package sfp_pkg;
    typedef enum logic [1:0] {
        SFP_FN_DAC  = 2'b00,
        SFP_FN_ADC  = 2'b01,
        SFP_FN_DIN  = 2'b10,
        SFP_FN_DOUT = 2'b11
    } sfp_fn_t;
    typedef enum logic [0:0] {
        SFP_ST_IDLE = 1'b0,
        SFP_ST_CONV = 1'b1
    } sfp_state_t;
    typedef struct packed {
        logic [`SFP_CH_W-1:0]   ch;
        logic [`SFP_CODE_W-1:0] code;
    } sfp_dac_t;
endpackage : sfp_pkg

// file: design/sfp_port.sv
// sfp_port: serial frame port with command fifo, pin functions and busy pin
// assumes an external host drives SCLK, SYNC_N and the input line; converter logic runs on SYS_CLK
`timescale 1ns/1ps
`include "sfp_defs.svh"

module sfp_fifo #(
    parameter int W     = `SFP_WORD_W,
    parameter int DEPTH = `SFP_FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic          push;
    logic          pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least two");
    end

    assign in_ready  = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage has no reset; count guards every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'h1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'h1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'h1;
            end
        end
    end
endmodule : sfp_fifo

module sfp_port #(
    parameter int FIFO_DEPTH = `SFP_FIFO_DEPTH
) (
    input  wire logic                   SYS_CLK,
    input  wire logic                   ARST_N,
    input  wire logic                   SCLK,
    input  wire logic                   SYNC_N,
    input  wire logic                   SERIAL_INPUT_LINE,
    output logic                        SERIAL_OUTPUT_LINE,
    input  wire logic [`SFP_PINS-1:0]   GENERAL_IO_IN,
    output logic      [`SFP_PINS-1:0]   GENERAL_IO_OUT,
    output logic      [`SFP_PINS-1:0]   GENERAL_IO_OE,
    output sfp_pkg::sfp_dac_t           DAC_REQ,
    output logic                        DAC_LOAD,
    output logic                        ADC_START,
    output logic      [`SFP_CH_W-1:0]   ADC_CH,
    input  wire logic                   ADC_DONE,
    input  wire logic [`SFP_CODE_W-1:0] ADC_RESULT,
    input  wire logic [`SFP_CODE_W-1:0] TEMP_CODE,
    output logic                        CMD_READY
);
    if (FIFO_DEPTH < 2) begin : g_bad_param
        $error("fifo depth too small");
    end

    // link side, on the host clock
    logic                   link_clr_n;
    logic [`SFP_CNT_W-1:0]  rx_cnt_r;
    logic [`SFP_WORD_W-1:0] rx_shift_r;
    logic [`SFP_WORD_W-1:0] rx_word_r;
    logic                   rx_tgl_r;
    logic [3:0]             tx_cnt_r;
    // system side
    logic                   sync_s1_r;
    logic                   sync_s2_r;
    logic                   tgl_s1_r;
    logic                   tgl_s2_r;
    logic                   tgl_s3_r;
    logic [`SFP_PINS-1:0]   gio_s1_r;
    logic [`SFP_PINS-1:0]   gio_s2_r;
    logic                   rx_evt;
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    logic [`SFP_WORD_W-1:0] cmd;
    logic                   pop;
    logic [3:0]             op;
    logic [`SFP_CH_W-1:0]   arg_pin;
    sfp_pkg::sfp_state_t    state_r;
    logic [`SFP_WORD_W-1:0] cfg_r;
    logic                   busy_en_r;
    logic [`SFP_PINS-1:0]   gpo_r;
    logic [`SFP_WORD_W-1:0] resp_r;
    logic                   resp_pend_r;
    logic [`SFP_WORD_W-1:0] tx_word_r;
    logic                   resp_set;
    logic [`SFP_WORD_W-1:0] resp_nxt;
    logic                   busy;
    logic [`SFP_PINS-1:0]   io_out_nxt;
    logic [`SFP_PINS-1:0]   io_oe_nxt;
    logic [`SFP_PINS-1:0]   din_mask;
    logic [`SFP_PINS-1:0]   io_out_r;
    logic [`SFP_PINS-1:0]   io_oe_r;
    sfp_pkg::sfp_dac_t      dac_r;
    logic                   dac_load_r;
    logic                   adc_start_r;
    logic [`SFP_CH_W-1:0]   adc_ch_r;
    logic                   cmd_ready_r;

    function automatic sfp_pkg::sfp_fn_t pin_fn(input logic [`SFP_WORD_W-1:0] cfg,
                                                input logic [`SFP_CH_W-1:0]   pin);
        pin_fn = sfp_pkg::sfp_fn_t'(cfg[{pin, 1'h0} +: 2]);
    endfunction : pin_fn

    // frame high clears the bit counters, so a partial word never completes
    assign link_clr_n = ARST_N && !SYNC_N;

    always_ff @(negedge SCLK or negedge link_clr_n) begin
        if (!link_clr_n) begin
            rx_cnt_r <= '0;
        end else if (rx_cnt_r != `SFP_FULL_CNT) begin
            rx_cnt_r <= rx_cnt_r + 1'h1;
        end
    end

    always_ff @(negedge SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_shift_r <= '0;
        end else begin
            rx_shift_r <= {rx_shift_r[`SFP_WORD_W-2:0], SERIAL_INPUT_LINE};
        end
    end

    // word held still for the system side until the next sixteenth fall
    always_ff @(negedge SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_word_r <= '0;
            rx_tgl_r  <= 1'h0;
        end else if (rx_cnt_r == `SFP_LAST_BIT) begin
            rx_word_r <= {rx_shift_r[`SFP_WORD_W-2:0], SERIAL_INPUT_LINE};
            rx_tgl_r  <= ~rx_tgl_r;
        end
    end

    // a rise moves out only after a fall has been seen, whatever the idle level
    always_ff @(posedge SCLK or negedge link_clr_n) begin
        if (!link_clr_n) begin
            tx_cnt_r <= '0;
        end else if ({1'h0, tx_cnt_r} < rx_cnt_r && tx_cnt_r != `SFP_MSB_IDX) begin
            tx_cnt_r <= tx_cnt_r + 1'h1;
        end
    end

    // counter cleared while framed high, so the msb stands at the frame fall
    assign SERIAL_OUTPUT_LINE = tx_word_r[`SFP_MSB_IDX - tx_cnt_r];

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_s1_r <= 1'h1;
            sync_s2_r <= 1'h1;
            tgl_s1_r  <= 1'h0;
            tgl_s2_r  <= 1'h0;
            tgl_s3_r  <= 1'h0;
            gio_s1_r  <= '0;
            gio_s2_r  <= '0;
        end else begin
            sync_s1_r <= SYNC_N;
            sync_s2_r <= sync_s1_r;
            tgl_s1_r  <= rx_tgl_r;
            tgl_s2_r  <= tgl_s1_r;
            tgl_s3_r  <= tgl_s2_r;
            gio_s1_r  <= GENERAL_IO_IN;
            gio_s2_r  <= gio_s1_r;
        end
    end

    assign rx_evt = tgl_s2_r ^ tgl_s3_r;

    // host cannot be stalled; a word arriving on a full fifo is lost
    sfp_fifo #(
        .W     (`SFP_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .arst_n    (ARST_N),
        .in_valid  (rx_evt),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_word_r),
        .out_valid (fifo_out_valid),
        .out_ready (state_r == sfp_pkg::SFP_ST_IDLE),
        .out_data  (cmd)
    );

    assign pop     = fifo_out_valid && (state_r == sfp_pkg::SFP_ST_IDLE);
    assign op      = cmd[`SFP_OP_HI:`SFP_OP_LO];
    assign arg_pin = cmd[`SFP_PIN_HI:`SFP_PIN_LO];
    assign busy    = (state_r == sfp_pkg::SFP_ST_CONV);

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r     <= sfp_pkg::SFP_ST_IDLE;
            adc_start_r <= 1'h0;
            adc_ch_r    <= '0;
        end else begin
            adc_start_r <= 1'h0;
            unique case (state_r)
                sfp_pkg::SFP_ST_IDLE: begin
                    if (pop && !cmd[`SFP_DAC_BIT] && op == `SFP_OP_CONV &&
                        pin_fn(cfg_r, cmd[`SFP_CH_W-1:0]) == sfp_pkg::SFP_FN_ADC) begin
                        state_r     <= sfp_pkg::SFP_ST_CONV;
                        adc_start_r <= 1'h1;
                        adc_ch_r    <= cmd[`SFP_CH_W-1:0];
                    end
                end
                sfp_pkg::SFP_ST_CONV: begin
                    if (ADC_DONE) begin
                        state_r <= sfp_pkg::SFP_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_r     <= `SFP_CFG_RST;
            busy_en_r <= 1'h0;
            gpo_r     <= `SFP_GPO_RST;
        end else if (pop && !cmd[`SFP_DAC_BIT]) begin
            if (op == `SFP_OP_FN) begin
                cfg_r[{arg_pin, 1'h0} +: 2] <= cmd[1:0];
            end
            if (op == `SFP_OP_BUSY) begin
                busy_en_r <= cmd[0];
            end
            if (op == `SFP_OP_GPO) begin
                gpo_r <= cmd[`SFP_PINS-1:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dac_r      <= '0;
            dac_load_r <= 1'h0;
        end else begin
            dac_load_r <= 1'h0;
            if (pop && cmd[`SFP_DAC_BIT] &&
                pin_fn(cfg_r, cmd[`SFP_CH_HI:`SFP_CH_LO]) == sfp_pkg::SFP_FN_DAC) begin
                dac_r.ch   <= cmd[`SFP_CH_HI:`SFP_CH_LO];
                dac_r.code <= cmd[`SFP_CODE_W-1:0];
                dac_load_r <= 1'h1;
            end
        end
    end

    always_comb begin
        resp_set = 1'h0;
        resp_nxt = resp_r;
        if (busy && ADC_DONE) begin
            resp_set = 1'h1;
            resp_nxt = {1'h0, adc_ch_r, ADC_RESULT};
        end else if (pop && !cmd[`SFP_DAC_BIT]) begin
            if (op == `SFP_OP_RB_CFG) begin
                resp_set = 1'h1;
                resp_nxt = cfg_r;
            end else if (op == `SFP_OP_RB_TEMP) begin
                resp_set = 1'h1;
                resp_nxt = {`SFP_TEMP_TAG, TEMP_CODE};
            end else if (op == `SFP_OP_RB_GPI) begin
                resp_set = 1'h1;
                resp_nxt = {8'h00, gio_s2_r & din_mask};
            end
        end
    end

    // output word only changes between frames, so the link reads it as static
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            resp_r      <= `SFP_TX_RST;
            resp_pend_r <= 1'h0;
            tx_word_r   <= `SFP_TX_RST;
        end else begin
            if (resp_set) begin
                resp_r      <= resp_nxt;
                resp_pend_r <= 1'h1;
            end else if (resp_pend_r && sync_s2_r) begin
                resp_pend_r <= 1'h0;
            end
            if (resp_pend_r && sync_s2_r) begin
                tx_word_r <= resp_r;
            end
        end
    end

    for (genvar i = 0; i < `SFP_PINS; i++) begin : g_pin
        localparam logic [`SFP_CH_W-1:0] PIN = `SFP_CH_W'(i);
        localparam bit IS_BUSY = (i == `SFP_BUSY_PIN);
        assign din_mask[i]   = (pin_fn(cfg_r, PIN) == sfp_pkg::SFP_FN_DIN);
        assign io_oe_nxt[i]  = (pin_fn(cfg_r, PIN) == sfp_pkg::SFP_FN_DOUT) || (IS_BUSY && busy_en_r);
        assign io_out_nxt[i] = (IS_BUSY && busy_en_r) ? busy : gpo_r[i];
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            io_out_r    <= '0;
            io_oe_r     <= '0;
            cmd_ready_r <= 1'h0;
        end else begin
            io_out_r    <= io_out_nxt;
            io_oe_r     <= io_oe_nxt;
            cmd_ready_r <= fifo_in_ready;
        end
    end

    assign GENERAL_IO_OUT = io_out_r;
    assign GENERAL_IO_OE  = io_oe_r;
    assign DAC_REQ        = dac_r;
    assign DAC_LOAD       = dac_load_r;
    assign ADC_START      = adc_start_r;
    assign ADC_CH         = adc_ch_r;
    assign CMD_READY      = cmd_ready_r;

    a_rx_count_cap: assert property (@(negedge SCLK) disable iff (!ARST_N)
        rx_cnt_r <= `SFP_FULL_CNT) else $error("input bit count past sixteen");
    a_word_on_last: assert property (@(negedge SCLK) disable iff (!ARST_N)
        $changed(rx_tgl_r) |-> $past(rx_cnt_r) == `SFP_LAST_BIT) else $error("word taken early");
    a_word_assembly: assert property (@(negedge SCLK) disable iff (!ARST_N)
        $changed(rx_tgl_r) |-> rx_word_r[0] == $past(SERIAL_INPUT_LINE)) else $error("lsb not last bit");
    a_tx_after_fall: assert property (@(posedge SCLK) disable iff (!link_clr_n)
        {1'h0, tx_cnt_r} <= rx_cnt_r) else $error("output ran ahead of falls");
    a_tx_frame_stable: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        !sync_s2_r && !$past(sync_s2_r) |-> $stable(tx_word_r)) else $error("output word moved in frame");
    a_push_lands: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        rx_evt && fifo_in_ready |=> fifo_out_valid) else $error("taken word missing from fifo");
    a_busy_start: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        adc_start_r |-> busy ##1 !adc_start_r) else $error("start without busy");
    a_busy_pin: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        busy_en_r && busy ##1 busy_en_r |-> GENERAL_IO_OE[`SFP_BUSY_PIN] && GENERAL_IO_OUT[`SFP_BUSY_PIN])
        else $error("busy pin not driven");
    a_dac_gated: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        dac_load_r |-> pin_fn($past(cfg_r), dac_r.ch) == sfp_pkg::SFP_FN_DAC) else $error("load on non dac pin");
    a_resp_to_tx: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        resp_set && sync_s2_r ##1 sync_s2_r |=> tx_word_r == $past(resp_r)) else $error("response not sent");

    c_frame_word: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) rx_evt);
    c_dac_load: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) dac_load_r);
    c_conv_done: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) busy && ADC_DONE);
    c_fifo_full: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) !fifo_in_ready);
endmodule : sfp_port

// file: verification/adc_dac_serial_frame_port_tb.sv
// adc_dac_serial_frame_port_tb: self-checking bench with a behavioural command model
// assumes sfp_host as the far side and the hand-over command encoding
`timescale 1ns/1ps
`include "sfp_defs.svh"
module adc_dac_serial_frame_port_tb;
    logic              sys_clk;
    logic              arst_n;
    logic              sclk;
    logic              sync_n;
    logic              sin;
    logic              sout;
    logic [7:0]        gio_in;
    logic [7:0]        gio_out;
    logic [7:0]        gio_oe;
    sfp_pkg::sfp_dac_t dac_req;
    logic              dac_load;
    logic              adc_start;
    logic [2:0]        adc_ch;
    logic              adc_done;
    logic [11:0]       adc_result;
    logic [11:0]       temp_code;
    logic              cmd_ready;
    logic [15:0]       rx;
    logic [15:0]       cfg_m;
    logic [7:0]        gpo_m;
    logic              busy_m;
    logic [11:0]       rnd;
    logic [7:0]        gpo_q[$];
    int                err_total;
    int                n_checks;
    int                hits;

    sfp_port #(.FIFO_DEPTH(16)) u_sfp_port (
        .SYS_CLK(sys_clk), .ARST_N(arst_n), .SCLK(sclk), .SYNC_N(sync_n),
        .SERIAL_INPUT_LINE(sin), .SERIAL_OUTPUT_LINE(sout), .GENERAL_IO_IN(gio_in),
        .GENERAL_IO_OUT(gio_out), .GENERAL_IO_OE(gio_oe), .DAC_REQ(dac_req), .DAC_LOAD(dac_load),
        .ADC_START(adc_start), .ADC_CH(adc_ch), .ADC_DONE(adc_done), .ADC_RESULT(adc_result),
        .TEMP_CODE(temp_code), .CMD_READY(cmd_ready)
    );
    sfp_host u_sfp_host (.sclk(sclk), .sync_n(sync_n), .sin(sin), .sout(sout));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle

    // one full frame, then the command model follows the word
    task automatic xfer(input logic [15:0] w);
        @(negedge sys_clk);
        #3;
        u_sfp_host.frame(w, 16, rx);
        if (!w[15] && w[14:11] == 4'h1) cfg_m[2*w[10:8]+:2] = w[1:0];
        if (!w[15] && w[14:11] == 4'h2) busy_m = w[0];
        if (!w[15] && w[14:11] == 4'h3) gpo_m = w[7:0];
        idle(12);
    endtask : xfer

    // sel 0 waits for a dac load, 1 for a conversion start
    task automatic wait_pulse(input int sel);
        hits = 0;
        for (int i = 0; i < 60 && hits == 0; i++) begin
            @(posedge sys_clk);
            #1;
            if ((sel == 0 && dac_load === 1'b1) || (sel == 1 && adc_start === 1'b1)) hits = 1;
        end
        if (hits == 0) begin
            err_total++;
            $display("Error at %0t: pulse %0d never came", $time, sel);
            print_verdict();
        end
    endtask : wait_pulse

    function automatic logic [15:0] pins_exp(input logic b);
        logic [7:0] oe;
        for (int i = 0; i < 8; i++) oe[i] = (cfg_m[2*i+:2] == 2'b11);
        oe[7] = oe[7] | busy_m;
        return {(busy_m ? {b, gpo_m[6:0]} : gpo_m) & oe, oe};
    endfunction : pins_exp

    initial begin
        arst_n     = 1'b0;
        gio_in     = 8'h00;
        adc_done   = 1'b0;
        adc_result = 12'h000;
        temp_code  = 12'h000;
        cfg_m      = `SFP_CFG_RST;
        gpo_m      = `SFP_GPO_RST;
        busy_m     = 1'b0;
        err_total  = 0;
        n_checks   = 0;
        void'($urandom(19183));
        idle(4);
        check({8'h00, gio_oe}, 16'h0000, "oe in reset");
        arst_n = 1'b1;
        idle(4);
        xfer(16'h2800);
        check(rx, `SFP_TX_RST, "first reply");
        xfer(16'h0000);
        check(rx, cfg_m, "default cfg");
        // every pin function once: pin0 dac, pin1 adc, pin2 din, rest dout
        for (int p = 0; p < 8; p++) xfer(16'h0800 | (p << 8) | ((p < 4) ? p : 3));
        xfer(16'h2800);
        xfer(16'h0000);
        check(rx, cfg_m, "cfg readback");
        xfer(16'h1800 | 16'($urandom() & 8'hff));
        check({gio_out & gio_oe, gio_oe}, pins_exp(1'b0), "pins");
        gio_in = 8'($urandom());
        xfer(16'h3800);
        xfer(16'h0000);
        check(rx, {8'h00, gio_in & 8'h04}, "din readback");
        temp_code = 12'($urandom());
        xfer(16'h3000);
        xfer(16'h0000);
        check(rx, {4'h8, temp_code}, "temp readback");
        rnd = 12'($urandom());
        @(negedge sys_clk);
        u_sfp_host.frame({4'h8, rnd}, 16, rx);
        wait_pulse(0);
        check({1'b0, dac_req}, {4'h0, rnd}, "dac request");
        // a dac write to a pin not in dac mode must not load
        @(negedge sys_clk);
        u_sfp_host.frame({4'hc, rnd}, 16, rx);
        hits = 0;
        // look just after the edge, never in the edge's own time step
        repeat (30) begin
            @(posedge sys_clk);
            #1;
            hits += (dac_load === 1'b1) ? 1 : 0;
        end
        check(16'(hits), 16'h0000, "ignored dac");
        xfer(16'h1001);
        @(negedge sys_clk);
        u_sfp_host.frame(16'h2001, 16, rx);
        wait_pulse(1);
        check({13'h0, adc_ch}, 16'h0001, "adc channel");
        idle(2);
        check({gio_out & gio_oe, gio_oe}, pins_exp(1'b1), "busy pin");
        // fifo stalls while busy: fill it past its depth
        for (int i = 1; i <= 18; i++) begin
            xfer(16'h1800 | 16'(i));
            if (gpo_q.size() < 16) gpo_q.push_back(8'(i));
        end
        check({15'h0, cmd_ready}, 16'h0000, "fifo full");
        adc_result = 12'($urandom());
        adc_done   = 1'b1;
        idle(1);
        adc_done = 1'b0;
        idle(60);
        gpo_m = gpo_q[$];
        check({gio_out & gio_oe, gio_oe}, pins_exp(1'b0), "drained");
        xfer(16'h0000);
        check(rx, {4'h1, adc_result}, "conversion result");
        // frame cut after 8 bits leaves the outputs alone
        @(negedge sys_clk);
        u_sfp_host.frame(16'h18ff, 8, rx);
        idle(12);
        check({gio_out & gio_oe, gio_oe}, pins_exp(1'b0), "aborted frame");
        arst_n = 1'b0;
        idle(2);
        check({7'h0, cmd_ready, gio_oe}, 16'h0000, "second reset");
        arst_n = 1'b1;
        cfg_m  = `SFP_CFG_RST;
        gpo_m  = `SFP_GPO_RST;
        busy_m = 1'b0;
        idle(4);
        check({gio_out & gio_oe, gio_oe}, pins_exp(1'b0), "pins after reset");
        xfer(16'h2800);
        xfer(16'h0000);
        check(rx, `SFP_CFG_RST, "cfg after reset");
        print_verdict();
    end

    initial begin
        #2000000;
        err_total++;
        $display("Error at %0t: run did not finish", $time);
        print_verdict();
    end
endmodule : adc_dac_serial_frame_port_tb

// file: verification/sfp_host.sv
// sfp_host: behavioural serial host that frames 16-bit words into the port
// assumes the bench calls frame() and gives the device time between frames
`timescale 1ns/1ps
module sfp_host (
    output logic      sclk,
    output logic      sync_n,
    output logic      sin,
    input  wire logic sout
);
    initial begin
        sclk   = 1'b1;
        sync_n = 1'b1;
        sin    = 1'b0;
    end
    // clock idles high and stands still between frames; 15 ns period set by the bench plan
    // host speed limits are the host's duty; the port has no speed limit of its own
    task automatic frame(input logic [15:0] w, input int nb, output logic [15:0] r);
        r      = 16'h0000;
        sync_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            sin = w[15-i]; // msb first
            #7.5;
            r    = {r[14:0], sout};
            sclk = 1'b0; // capture edge
            #7.5;
            sclk = 1'b1; // next output bit
        end
        #7.5;
        sync_n = 1'b1;
        sin    = ~sin; // released line must not look stale
    endtask : frame
endmodule : sfp_host
